/* File: include/iao_pkg.sv */
// constants shared by the indexed operand and operation error unit
package iao_pkg;
    // ======================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00; // mode and error action
    localparam logic [7:0] OFS_CMD    = 8'h04; // write executes
    localparam logic [7:0] OFS_OPA    = 8'h08; // base number or constant
    localparam logic [7:0] OFS_OPB    = 8'h0C; // divisor, length, data
    localparam logic [7:0] OFS_RESULT = 8'h10; // last result
    localparam logic [7:0] OFS_STATUS = 8'h14; // flags and state
    localparam logic [7:0] OFS_ECODE  = 8'h18; // error_code_word
    localparam logic [7:0] OFS_EADRL  = 8'h1C; // error_address_low_word
    localparam logic [7:0] OFS_EADRH  = 8'h20; // error_address_high_word
    localparam logic [7:0] OFS_PADDR  = 8'h24; // current program address
    localparam logic [7:0] OFS_CLEAR  = 8'h28; // clear actions
    localparam logic [7:0] OFS_INDEX  = 8'h40; // first of 14 index words
    // ======================================================
    // field positions
    localparam int CTRL_CONT = 0;  // continue on operation error
    localparam int CTRL_RUN  = 1;  // mode selector at run
    localparam int CTRL_HOLD = 2;  // index words are hold type
    localparam int CLR_DIAG  = 0;  // self_diag_error_set_instr
    localparam int CLR_TOOL  = 1;  // tool clear
    localparam int CLR_PWR   = 2;  // power cycle in program_mode
    // ======================================================
    // sizes, codes and limits
    localparam int          NUM_INDEX  = 14;
    localparam logic [15:0] ERR_CODE   = 16'h002D; // code 45
    localparam logic [31:0] DR_MAX     = 32'h00007FFC; // 32764
    localparam logic [31:0] WX_MAX     = 32'h000001FF;
    localparam logic [31:0] WY_MAX     = 32'h000001FF;
    localparam logic [31:0] WR_MAX     = 32'h000000FF;
    localparam logic [31:0] TMR_MAX    = 32'h000003FF;
    localparam logic [15:0] BCD_MAX    = 16'h270F;     // 9999
    localparam logic [31:0] RST_VAL    = 32'h00000000;
    localparam int          BLINK_MS   = 250;
    localparam int          CLK_MHZ    = 200;
    localparam int          BLINK_CYC  = BLINK_MS * 1000 * CLK_MHZ;
    // ======================================================
    // operations, areas, error kinds, states
    typedef enum logic [2:0] {
        OP_ADDR = 3'h0, OP_CONST = 3'h1, OP_BCD2BIN = 3'h2,
        OP_BIN2BCD = 3'h3, OP_DIV = 3'h4, OP_PARAM = 3'h5,
        OP_BLOCK = 3'h6, OP_NONE = 3'h7
    } iao_op_t;
    typedef enum logic [2:0] {
        AR_WX = 3'h0, AR_WY = 3'h1, AR_WR = 3'h2, AR_SV = 3'h3,
        AR_EV = 3'h4, AR_DT = 3'h5, AR_K = 3'h6, AR_IX = 3'h7
    } iao_area_t;
    localparam logic [3:0] EK_ADDR  = 4'h1; // address error
    localparam logic [3:0] EK_BCD   = 4'h2; // bcd data error
    localparam logic [3:0] EK_PARAM = 4'h4; // parameter error
    localparam logic [3:0] EK_AREA  = 4'h8; // over area error
    localparam logic [3:0] NO_INDEX = 4'hF; // no modification
    typedef enum logic [2:0] {
        ST_STOP = 3'b001, ST_RUN = 3'b010, ST_HALT = 3'b100
    } iao_state_t;
endpackage : iao_pkg

/* File: hw/iao_unit.sv */
// indexed operand forming and operation error unit, apb slave
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - fourteen readable writable 16-bit index words
// - effective number is base plus index
// - indexing works on all word areas
// - constants may be index modified too
// - index words cannot index index words
// - 32-bit op with first index pairs two
// - error sets both flags, blinks indicator
// - error writes fixed code to code word
// - error stores faulting address in two words
// - out of range indexed number: address error
// - non-bcd or unconvertible data: bcd error
// - control data out of range: parameter error
// - block past area end: over area error
// - halt on error unless continuation selected
// - self diagnostic set instruction clears error
// - run selector resumes run after clear
// - program mode power cycle clears non-hold
// - data register number 0..32764 only
// - bcd to binary conversion provided
// - binary to bcd conversion provided
// - each decimal digit coded separately
// - digit ten to fifteen fails conversion
// - negative or above 9999 fails conversion
// - zero divisor raises operation error
module iao_unit #(
    parameter int BLINK_CYC = iao_pkg::BLINK_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // status pins
    output logic             op_error_flag_hold,
    output logic             op_error_flag_latest,
    output logic             err_led,
    output logic             running
);
    // ======================================================
    // reset release
    logic rst_m_r, rst_s_r; // rst_s_r is the design reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end

    // ======================================================
    // apb handshake: one wait state so prdata is a flop
    logic        acc_w;    // access phase, data not yet given
    logic        done_w;   // edge at which the transfer ends
    logic        wr_w;     // write takes effect now
    logic        hit_w;    // address is mapped
    logic        ix_hit_w; // address is an index word
    logic [3:0]  ix_a_w;   // index word number from address
    logic [31:0] rd_w;     // read mux
    assign acc_w   = psel & penable & ~pready;
    assign done_w  = psel & penable & pready;
    assign wr_w    = done_w & pwrite & hit_w;
    assign ix_a_w  = paddr[5:2];
    assign ix_hit_w = (paddr[7:6] == 2'b01) && (paddr[1:0] == 2'b00)
                    && (ix_a_w < 4'(iao_pkg::NUM_INDEX));
    assign hit_w = ix_hit_w || (paddr[1:0] == 2'b00
                 && paddr <= iao_pkg::OFS_CLEAR);

    // ======================================================
    // control and operand registers
    logic [2:0]  ctrl_r;   // cont, run selector, hold
    logic [31:0] opa_r, opb_r, paddr_r, result_r;
    logic [15:0] ecode_r, eadrl_r, eadrh_r;
    logic [3:0]  ekind_r;  // kinds seen since last clear
    logic        fh_r, fl_r; // error flags
    logic [15:0] idx_r [iao_pkg::NUM_INDEX]; // index words
    iao_pkg::iao_state_t st_r, st_nxt;

    // ======================================================
    // clear decode
    logic clr_w;  // any clear of the error record
    logic pwr_w;  // power cycle action in program mode
    assign pwr_w = wr_w && paddr == iao_pkg::OFS_CLEAR
                 && pwdata[iao_pkg::CLR_PWR]
                 && !ctrl_r[iao_pkg::CTRL_RUN];
    assign clr_w = (wr_w && paddr == iao_pkg::OFS_CLEAR
                 && (pwdata[iao_pkg::CLR_DIAG]
                  || pwdata[iao_pkg::CLR_TOOL])) || pwr_w;

    // ======================================================
    // command decode; taken only while running
    logic            exec_w;
    iao_pkg::iao_op_t   op_w;
    iao_pkg::iao_area_t ar_w;
    logic [3:0]      sel_w;  // index word chosen
    logic            wide_w; // 32-bit instruction
    assign exec_w = wr_w && paddr == iao_pkg::OFS_CMD
                  && st_r == iao_pkg::ST_RUN;
    assign op_w   = iao_pkg::iao_op_t'(pwdata[2:0]);
    assign ar_w   = iao_pkg::iao_area_t'(pwdata[6:4]);
    assign sel_w  = pwdata[11:8];
    assign wide_w = pwdata[12];

    // ======================================================
    // effective number, signed index
    logic        use_w;
    logic [31:0] ixv_w;  // index value, sign extended
    logic [33:0] eff_w;  // base plus index, signed
    logic [33:0] end_w;  // last number of a block
    logic [31:0] max_w;  // last usable number of the area
    assign use_w = sel_w < 4'(iao_pkg::NUM_INDEX);
    assign ixv_w = !use_w ? 32'h00000000
                 : (wide_w && sel_w == 4'h0)
                 ? {idx_r[1], idx_r[0]}
                 : {{16{idx_r[sel_w][15]}}, idx_r[sel_w]};
    assign eff_w = {2'b00, opa_r}
                 + {{2{ixv_w[31]}}, ixv_w};
    assign end_w = eff_w + {2'b00, opb_r} - 34'h1;
    assign max_w = ar_w == iao_pkg::AR_WX ? iao_pkg::WX_MAX
                 : ar_w == iao_pkg::AR_WY ? iao_pkg::WY_MAX
                 : ar_w == iao_pkg::AR_WR ? iao_pkg::WR_MAX
                 : ar_w == iao_pkg::AR_DT ? iao_pkg::DR_MAX
                 : iao_pkg::TMR_MAX;

    // ======================================================
    // error checks
    logic e_addr_w, e_area_w, e_bcd_w, e_par_w, e_div_w;
    logic chk_w;    // operation addresses memory
    logic dig_bad_w; // a bcd digit above nine
    logic [15:0] v_w; // operand word after modification
    assign chk_w  = op_w == iao_pkg::OP_ADDR
                  || op_w == iao_pkg::OP_BLOCK;
    assign v_w    = eff_w[15:0];
    assign e_addr_w = chk_w && (ar_w == iao_pkg::AR_IX
                  || (ar_w != iao_pkg::AR_K && (eff_w[33]
                  || eff_w[31:0] > max_w)));
    assign e_area_w = op_w == iao_pkg::OP_BLOCK && !e_addr_w
                  && ar_w != iao_pkg::AR_K
                  && (opb_r == 32'h0 || end_w[33]
                  || end_w[31:0] > max_w);
    assign dig_bad_w = (v_w[15:12] > 4'h9) || (v_w[11:8] > 4'h9)
                  || (v_w[7:4] > 4'h9) || (v_w[3:0] > 4'h9);
    assign e_bcd_w = (op_w == iao_pkg::OP_BCD2BIN && dig_bad_w)
                  || (op_w == iao_pkg::OP_BIN2BCD && (v_w[15]
                  || v_w > iao_pkg::BCD_MAX));
    assign e_par_w = op_w == iao_pkg::OP_PARAM
                  && opb_r > eff_w[31:0];
    assign e_div_w = op_w == iao_pkg::OP_DIV
                  && opb_r == 32'h0;

    logic       err_w;   // operation error this command
    logic [3:0] kind_w;
    assign kind_w = {e_area_w, e_par_w | e_div_w, e_bcd_w, e_addr_w};
    assign err_w  = exec_w && kind_w != 4'h0;

    // ======================================================
    // conversions, four-bit digits
    logic [15:0] bin_w, bcd_w;
    assign bin_w = 16'(v_w[15:12]) * 16'd1000 + 16'(v_w[11:8]) * 16'd100
                 + 16'(v_w[7:4]) * 16'd10 + 16'(v_w[3:0]);
    assign bcd_w = {4'(v_w / 16'd1000), 4'((v_w / 16'd100) % 16'd10),
                    4'((v_w / 16'd10) % 16'd10),
                    4'(v_w % 16'd10)};

    logic [31:0] res_w;
    assign res_w = op_w == iao_pkg::OP_BCD2BIN ? {16'h0000, bin_w}
                 : op_w == iao_pkg::OP_BIN2BCD ? {16'h0000, bcd_w}
                 : eff_w[31:0];

    // ======================================================
    // run state: stop in program mode, halt on error
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            iao_pkg::ST_STOP: begin
                if (ctrl_r[iao_pkg::CTRL_RUN] && !fh_r) begin
                    st_nxt = iao_pkg::ST_RUN;
                end
            end
            iao_pkg::ST_RUN: begin
                if (err_w && !ctrl_r[iao_pkg::CTRL_CONT]) begin
                    st_nxt = iao_pkg::ST_HALT;
                end else if (!ctrl_r[iao_pkg::CTRL_RUN]) begin
                    st_nxt = iao_pkg::ST_STOP;
                end
            end
            iao_pkg::ST_HALT: begin
                if (clr_w) begin
                    st_nxt = ctrl_r[iao_pkg::CTRL_RUN]
                           ? iao_pkg::ST_RUN : iao_pkg::ST_STOP;
                end
            end
            default: st_nxt = iao_pkg::ST_STOP;
        endcase
    end

    // state and control flops
    always_ff @(posedge mclk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            st_r    <= iao_pkg::ST_STOP;
            ctrl_r  <= 3'h0;
            opa_r   <= iao_pkg::RST_VAL;
            opb_r   <= iao_pkg::RST_VAL;
            paddr_r <= iao_pkg::RST_VAL;
        end else begin
            st_r <= st_nxt;
            if (wr_w && paddr == iao_pkg::OFS_CTRL) ctrl_r <= pwdata[2:0];
            if (wr_w && paddr == iao_pkg::OFS_OPA)  opa_r  <= pwdata;
            if (wr_w && paddr == iao_pkg::OFS_OPB)  opb_r  <= pwdata;
            if (wr_w && paddr == iao_pkg::OFS_PADDR) paddr_r <= pwdata;
        end
    end

    // ======================================================
    // index words; a program mode power cycle clears them
    // unless they are marked hold type
    generate
        for (genvar gi = 0; gi < iao_pkg::NUM_INDEX; gi++) begin : g_ix
            always_ff @(posedge mclk or negedge rst_s_r) begin
                if (!rst_s_r) begin
                    idx_r[gi] <= 16'h0000;
                end else if (wr_w && ix_hit_w
                             && ix_a_w == 4'(gi)) begin
                    idx_r[gi] <= pwdata[15:0];
                end else if (pwr_w && !ctrl_r[iao_pkg::CTRL_HOLD]) begin
                    idx_r[gi] <= 16'h0000;
                end
            end
        end
    endgenerate

    // ======================================================
    // error record: a new error wins over a clear
    always_ff @(posedge mclk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            fh_r    <= 1'b0;
            fl_r    <= 1'b0;
            ekind_r <= 4'h0;
            ecode_r <= 16'h0000;
            eadrl_r <= 16'h0000;
            eadrh_r <= 16'h0000;
        end else if (err_w) begin
            fh_r    <= 1'b1;
            fl_r    <= 1'b1;
            ekind_r <= (clr_w ? 4'h0 : ekind_r) | kind_w;
            ecode_r <= iao_pkg::ERR_CODE;
            eadrl_r <= paddr_r[15:0];
            eadrh_r <= paddr_r[31:16];
        end else if (clr_w) begin
            fh_r    <= 1'b0;
            fl_r    <= 1'b0;
            ekind_r <= 4'h0;
            ecode_r <= 16'h0000;
            eadrl_r <= 16'h0000;
            eadrh_r <= 16'h0000;
        end
    end

    // result keeps its value on a failed command
    always_ff @(posedge mclk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            result_r <= iao_pkg::RST_VAL;
        end else if (pwr_w) begin
            result_r <= iao_pkg::RST_VAL;
        end else if (exec_w && !err_w) begin
            result_r <= res_w;
        end
    end

    // ======================================================
    // indicator blink while an error stands
    logic [31:0] blk_r;
    always_ff @(posedge mclk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            blk_r   <= 32'h00000000;
            err_led <= 1'b0;
        end else if (!fh_r) begin
            blk_r   <= 32'h00000000;
            err_led <= 1'b0;
        end else if (blk_r >= 32'(BLINK_CYC - 1)) begin
            blk_r   <= 32'h00000000;
            err_led <= ~err_led;
        end else begin
            blk_r   <= blk_r + 32'h00000001;
        end
    end

    // ======================================================
    // read mux and bus outputs
    assign rd_w = ix_hit_w ? {16'h0000, idx_r[ix_a_w]}
        : paddr == iao_pkg::OFS_CTRL   ? {29'h0, ctrl_r}
        : paddr == iao_pkg::OFS_OPA    ? opa_r
        : paddr == iao_pkg::OFS_OPB    ? opb_r
        : paddr == iao_pkg::OFS_RESULT ? result_r
        : paddr == iao_pkg::OFS_STATUS ? {22'h0, st_r, ekind_r,
                                          err_led, fl_r, fh_r}
        : paddr == iao_pkg::OFS_ECODE  ? {16'h0000, ecode_r}
        : paddr == iao_pkg::OFS_EADRL  ? {16'h0000, eadrl_r}
        : paddr == iao_pkg::OFS_EADRH  ? {16'h0000, eadrh_r}
        : paddr == iao_pkg::OFS_PADDR  ? paddr_r
        : 32'h00000000;

    always_ff @(posedge mclk or negedge rst_s_r) begin
        if (!rst_s_r) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
            op_error_flag_hold   <= 1'b0;
            op_error_flag_latest <= 1'b0;
            running <= 1'b0;
        end else begin
            pready  <= acc_w;
            pslverr <= acc_w & ~hit_w;
            if (acc_w) prdata <= pwrite ? 32'h00000000 : rd_w;
            op_error_flag_hold   <= fh_r;
            op_error_flag_latest <= fl_r;
            running <= st_r == iao_pkg::ST_RUN;
        end
    end

    // ======================================================
    // checks
    sequence s_err;
        err_w;
    endsequence
    sequence s_rec;
        fh_r && fl_r && ecode_r == iao_pkg::ERR_CODE;
    endsequence

    property p_err_rec;
        @(posedge mclk) disable iff (!rst_s_r)
        s_err |=> s_rec ##1 op_error_flag_hold;
    endproperty
    a_err_rec: assert property (p_err_rec)
        else $error("error record not set");

    property p_err_adr;
        @(posedge mclk) disable iff (!rst_s_r)
        err_w |=> {eadrh_r, eadrl_r} == $past(paddr_r);
    endproperty
    a_err_adr: assert property (p_err_adr)
        else $error("error address wrong");

    property p_halt;
        @(posedge mclk) disable iff (!rst_s_r)
        err_w && !ctrl_r[0] |=> st_r == iao_pkg::ST_HALT ##1 !running;
    endproperty
    a_halt: assert property (p_halt)
        else $error("no halt on error");

    property p_cont;
        @(posedge mclk) disable iff (!rst_s_r)
        err_w && ctrl_r[0] && ctrl_r[1] |=> st_r == iao_pkg::ST_RUN;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuation not kept");

    property p_sticky;
        @(posedge mclk) disable iff (!rst_s_r)
        fh_r && !clr_w |=> fh_r && fl_r;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");

    property p_resume;
        @(posedge mclk) disable iff (!rst_s_r)
        st_r == iao_pkg::ST_HALT && clr_w && !err_w && ctrl_r[1]
        |=> st_r == iao_pkg::ST_RUN && !fh_r ##1 running;
    endproperty
    a_resume: assert property (p_resume)
        else $error("no resume after clear");

    property p_div0;
        @(posedge mclk) disable iff (!rst_s_r)
        exec_w && op_w == iao_pkg::OP_DIV && opb_r == 32'h0 |=> fh_r;
    endproperty
    a_div0: assert property (p_div0)
        else $error("zero divisor missed");

    property p_dr;
        @(posedge mclk) disable iff (!rst_s_r)
        exec_w && op_w == iao_pkg::OP_ADDR && ar_w == iao_pkg::AR_DT
        && eff_w > {2'b00, iao_pkg::DR_MAX} |=> fh_r && ekind_r[0];
    endproperty
    a_dr: assert property (p_dr)
        else $error("data register range missed");

    property p_apb;
        @(posedge mclk) disable iff (!rst_s_r)
        psel && !penable |=> !pready ##1 pready;
    endproperty
    a_apb: assert property (p_apb)
        else $error("apb wait state wrong");
endmodule : iao_unit

/* File: tb/tb_top.sv */
// self-checking bench for the indexed operand and operation error unit
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // stimulus and observed signals
    logic        mclk = 1'b0;     // 200 mhz clock
    logic        rst_b = 1'b0;    // active low reset
    logic        psel = 1'b0;     // apb select
    logic        penable = 1'b0;  // apb access phase
    logic        pwrite = 1'b0;   // apb direction
    logic [7:0]  paddr = 8'h00;   // apb byte address
    logic [31:0] pwdata = 32'h0;  // apb write data
    logic        pready, pslverr, hold_f, last_f, led, running;
    logic [31:0] prdata;          // apb read data
    int          errors = 0;      // mismatch count
    int          compares = 0;    // comparison count
    always #2.5 mclk = ~mclk;
    // short blink count keeps the indicator observable in sim
    iao_unit #(.BLINK_CYC(8)) i_iao_unit (
        .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .op_error_flag_hold(hold_f), .op_error_flag_latest(last_f),
        .err_led(led), .running(running));
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; waits on pready rather than assuming latency
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rd
    // ==========================================================
    // scenarios
    task automatic t_index;
        logic [31:0] r;
        logic        e;
        wr(8'h74, 32'h0001_A5C3);
        rd(8'h74, 32'h0000_A5C3);
        apb(1'b0, 8'hFC, 32'h0, r, e);
        chk({31'h0, e}, 32'h1); // unmapped place is refused
        $display("test index done");
    endtask : t_index
    task automatic t_addr;
        wr(iao_pkg::OFS_CTRL, 32'h3);   // run, continue on error
        rd(iao_pkg::OFS_STATUS, 32'h0000_0100);
        wr(8'h40, 32'hA);
        wr(8'h44, 32'h1);
        wr(iao_pkg::OFS_OPA, 32'd100);
        wr(iao_pkg::OFS_CMD, 32'h0050); // data reg plus first word
        rd(iao_pkg::OFS_RESULT, 32'd110);
        wr(iao_pkg::OFS_OPA, 32'd200);
        wr(iao_pkg::OFS_CMD, 32'h0010); // output word area
        rd(iao_pkg::OFS_RESULT, 32'd210);
        wr(iao_pkg::OFS_OPA, 32'd5);
        wr(iao_pkg::OFS_CMD, 32'h0061); // indexed constant
        rd(iao_pkg::OFS_RESULT, 32'd15);
        wr(iao_pkg::OFS_OPA, 32'd0);
        wr(iao_pkg::OFS_CMD, 32'h1050); // pair gives 0x1000A
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        chk({30'h0, hold_f, last_f}, 32'h3);
        rd(iao_pkg::OFS_RESULT, 32'd15);
        chk({31'h0, running}, 32'h1);
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        rd(iao_pkg::OFS_ECODE, 32'h0);
        wr(iao_pkg::OFS_CMD, 32'h0070); // index area as target
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        wr(8'h40, 32'hFFFF);            // minus one, signed
        wr(iao_pkg::OFS_CMD, 32'h0050);
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        $display("test addressing done");
    endtask : t_addr
    task automatic t_bcd;
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        wr(iao_pkg::OFS_OPA, 32'h1234);
        wr(iao_pkg::OFS_CMD, 32'h0F02);
        rd(iao_pkg::OFS_RESULT, 32'h04D2);
        wr(iao_pkg::OFS_OPA, 32'h270F);
        wr(iao_pkg::OFS_CMD, 32'h0F03);
        rd(iao_pkg::OFS_RESULT, 32'h9999);
        wr(iao_pkg::OFS_OPA, 32'h12A4);
        wr(iao_pkg::OFS_CMD, 32'h0F02);
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        wr(iao_pkg::OFS_OPA, 32'h2710);
        wr(iao_pkg::OFS_CMD, 32'h0F03);
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        wr(iao_pkg::OFS_OPA, 32'd250);
        wr(iao_pkg::OFS_OPB, 32'd10);
        wr(iao_pkg::OFS_CMD, 32'h0F26); // relay words 250 to 259
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        wr(iao_pkg::OFS_OPA, 32'd5);
        wr(iao_pkg::OFS_CMD, 32'h0F05); // control data 10 above 5
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        $display("test bcd done");
    endtask : t_bcd
    task automatic t_halt;
        logic l0;  // indicator level one blink period earlier
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        wr(iao_pkg::OFS_CTRL, 32'h2);   // run, halt on error
        wr(iao_pkg::OFS_OPB, 32'h0);
        wr(iao_pkg::OFS_PADDR, 32'h0003_1234); // faulting address
        wr(iao_pkg::OFS_CMD, 32'h0F04);
        rd(iao_pkg::OFS_ECODE, 32'h2D);
        rd(iao_pkg::OFS_EADRL, 32'h1234);
        rd(iao_pkg::OFS_EADRH, 32'h0003);
        chk({31'h0, running}, 32'h0);
        // blink period is the 8 cycles set at the instance
        l0 = led;
        repeat (8) @(posedge mclk);
        chk({31'h0, led}, {31'h0, ~l0});
        wr(iao_pkg::OFS_CLEAR, 32'h1);
        rd(iao_pkg::OFS_ECODE, 32'h0);
        chk({28'h0, led, running, hold_f, last_f}, 32'h4);
        wr(iao_pkg::OFS_CTRL, 32'h4);   // program mode, hold type index
        wr(8'h48, 32'h0055);
        wr(iao_pkg::OFS_CLEAR, 32'h4);  // power cycle
        rd(8'h48, 32'h0055);
        wr(iao_pkg::OFS_CTRL, 32'h0);   // program mode, no hold
        wr(iao_pkg::OFS_CLEAR, 32'h4);
        rd(8'h48, 32'h0);
        $display("test halt done");
    endtask : t_halt
    // ==========================================================
    // verdict
    task automatic close_out;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // watchdog well beyond the few hundred cycles the tests use
    initial begin
        #100000;
        errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        t_index();
        t_addr();
        t_bcd();
        t_halt();
        close_out();
    end
endmodule : tb_top
